// [logic/agpc_pin_cell.sv]
`default_nettype none
// ==========================================================================
// one multifunction pin: mode decode and registered pad controls
module agpc_pin_cell
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration
  input wire logic digital_pin_select,
  input wire logic pin_direction_select,
  input wire logic pin_drive_value,
  input wire logic serial_active,
  input wire logic serial_pull_low,
  // pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic input_pulldown_resistor,
  output logic input_buf_en,
  output logic analog_sel,
  output logic level_seen
);
  logic gpio_on;
  assign gpio_on = !serial_active && digital_pin_select;

  // ==========================================================================
  // pad controls
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      input_pulldown_resistor <= 1'b1;
      input_buf_en <= 1'b1;
      analog_sel <= 1'b0;
    end
    else
    begin
      // open drain under the serial controller: only ever pull low
      pin_out <= serial_active ? 1'b0 : pin_drive_value;
      pin_oe <= serial_active ? serial_pull_low
                              : (gpio_on && pin_direction_select);
      input_pulldown_resistor <= gpio_on && !pin_direction_select;
      input_buf_en <= serial_active || digital_pin_select;
      analog_sel <= !serial_active && !digital_pin_select;
    end
  end

  // ==========================================================================
  // sampled level, zero unless the pin is a gpio
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      level_seen <= 1'b0;
    else
      level_seen <= gpio_on ? pin_in : 1'b0;
  end
endmodule // agpc_pin_cell
`default_nettype wire

// [logic/agpc_pkg.sv]
`default_nettype none
// ==========================================================================
// shared constants for the auxiliary pin configuration block
package agpc_pkg;
  localparam int AGPC_PINS = 6;
  localparam int AGPC_ADDR_W = 12;
  localparam int AGPC_REG_W = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] MODE_CFG_INDEX = 8'h16;
  localparam logic [7:0] DRIVE_CFG_INDEX = 8'h17;
  localparam logic [11:0] MODE_CFG_ADDR = {2'h0, MODE_CFG_INDEX, 2'h0};
  localparam logic [11:0] DRIVE_CFG_ADDR = {2'h0, DRIVE_CFG_INDEX, 2'h0};
  // mode register fields
  localparam int SERIAL_SEL_BIT = 15;
  localparam int DIGITAL_SEL_LSB = 8;
  localparam int DIRECTION_LSB = 0;
  localparam logic [15:0] MODE_CFG_RESET = 16'h3f00;
  localparam logic [15:0] MODE_CFG_WMASK = 16'hbf3f;
  // drive register fields
  localparam int DRIVE_VALUE_LSB = 8;
  localparam int LEVEL_SEEN_LSB = 0;
  localparam logic [15:0] DRIVE_CFG_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_CFG_WMASK = 16'h3f00;
  // pins taken over by the serial controller
  localparam int SDA_PIN = 0;
  localparam int SCL_PIN = 1;
  localparam int SERIAL_PINS = 2;
endpackage
`default_nettype wire

// [logic/agpc_top.sv]
`default_nettype none
// Overview of operation
// - bit 15 selects serial controller, default off
// - serial mode: pin0 open-drain data, pin1 clock
// - serial mode overrides all other pin0/1 settings
// - digital select bit: 0 analog, 1 gpio
// - pin0/1 digital select still stored, read back
// - direction bit: 0 input, 1 output, gpio only
// - gpio input enables weak pull-down, else off
// - output mode keeps input buffer active
// - pin0/1 direction still stored, read back
// - gpio output drives its drive-value bit
module agpc_top
  import agpc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AGPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial controller engine
  input wire logic sda_pull_low,
  input wire logic scl_pull_low,
  output logic sda_level,
  // pads
  input wire logic [AGPC_PINS-1:0] pin_in,
  output logic [AGPC_PINS-1:0] pin_out,
  output logic [AGPC_PINS-1:0] pin_oe,
  output logic [AGPC_PINS-1:0] input_pulldown_resistor,
  output logic [AGPC_PINS-1:0] input_buf_en,
  output logic [AGPC_PINS-1:0] analog_sel
);
  logic [AGPC_REG_W-1:0] mode_cfg;
  logic [AGPC_REG_W-1:0] drive_cfg;
  logic [AGPC_PINS-1:0] level_seen;
  logic setup_phase;
  logic write_done;
  logic addr_mode;
  logic addr_drive;
  logic [AGPC_REG_W-1:0] next_read;

  // expands the two low byte strobes into a bit mask
  function automatic logic [AGPC_REG_W-1:0] lane_mask(input logic [3:0] strobes);
    lane_mask = {{8{strobes[1]}}, {8{strobes[0]}}};
  endfunction

  function automatic logic [AGPC_REG_W-1:0] merge_write(
    input logic [AGPC_REG_W-1:0] old_value,
    input logic [31:0] data,
    input logic [3:0] strobes,
    input logic [AGPC_REG_W-1:0] wmask);
    logic [AGPC_REG_W-1:0] keep;
    keep = ~(lane_mask(strobes) & wmask);
    merge_write = (old_value & keep) | (data[AGPC_REG_W-1:0] & ~keep);
  endfunction

  assign setup_phase = psel && !penable;
  assign write_done = psel && penable && pready && pwrite && !pslverr;
  assign addr_mode = (paddr == MODE_CFG_ADDR);
  assign addr_drive = (paddr == DRIVE_CFG_ADDR);

  always_comb
  begin
    next_read = '0;
    if (addr_mode)
      next_read = mode_cfg;
    else if (addr_drive)
      next_read = {drive_cfg[15:8], 2'h0, level_seen};
  end

  // ==========================================================================
  // apb handshake: one wait-free access cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup_phase;
      if (setup_phase)
      begin
        pslverr <= !(addr_mode || addr_drive);
        prdata <= {16'h0000, next_read};
      end
      else
        pslverr <= 1'b0;
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mode_cfg <= MODE_CFG_RESET;
    else if (write_done && addr_mode)
      // masked bits never store, so reserved positions stay zero
      mode_cfg <= merge_write(mode_cfg, pwdata, pstrb, MODE_CFG_WMASK);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      drive_cfg <= DRIVE_CFG_RESET;
    else if (write_done && addr_drive)
      drive_cfg <= merge_write(drive_cfg, pwdata, pstrb, DRIVE_CFG_WMASK);
  end

  // ==========================================================================
  // sda level to the serial engine; pins sampled straight, taken as synchronous
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      sda_level <= 1'b1;
    else
      sda_level <= pin_in[SDA_PIN];
  end

  // ==========================================================================
  // pin cells
  genvar gi;
  generate
    for (gi = 0; gi < AGPC_PINS; gi++)
    begin : g_pin
      logic serial_active;
      logic serial_pull_low;
      assign serial_active = mode_cfg[SERIAL_SEL_BIT] && (gi < SERIAL_PINS);
      assign serial_pull_low = (gi == SDA_PIN) ? sda_pull_low : scl_pull_low;
      agpc_pin_cell u_cell
      (
        .clock(clock),
        .rstn(rstn),
        .digital_pin_select(mode_cfg[DIGITAL_SEL_LSB+gi]),
        .pin_direction_select(mode_cfg[DIRECTION_LSB+gi]),
        .pin_drive_value(drive_cfg[DRIVE_VALUE_LSB+gi]),
        .serial_active(serial_active),
        .serial_pull_low(serial_pull_low),
        .pin_in(pin_in[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .input_pulldown_resistor(input_pulldown_resistor[gi]),
        .input_buf_en(input_buf_en[gi]),
        .analog_sel(analog_sel[gi]),
        .level_seen(level_seen[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_mode_setup_read;
    psel && !penable && !pwrite && addr_mode;
  endsequence

  sequence s_mode_write;
    psel && penable && pready && pwrite && addr_mode && pstrb[1] && pstrb[0];
  endsequence

  a_reserved_bits_zero: assert property (mode_cfg[14] == 1'b0 && mode_cfg[7:6] == 2'b00)
    else $error("reserved mode bits not zero");

  a_mode_write_lands: assert property (s_mode_write |=>
    mode_cfg == ($past(pwdata[15:0]) & MODE_CFG_WMASK))
    else $error("mode register write not stored");

  a_sda_open_drain: assert property (mode_cfg[SERIAL_SEL_BIT] ##1 mode_cfg[SERIAL_SEL_BIT] |->
    pin_out[SDA_PIN] == 1'b0 && pin_oe[SDA_PIN] == $past(sda_pull_low))
    else $error("sda pin not open drain");

  a_scl_open_drain: assert property (
    mode_cfg[SERIAL_SEL_BIT] ##1 mode_cfg[SERIAL_SEL_BIT] |->
    pin_out[SCL_PIN] == 1'b0 && input_buf_en[SCL_PIN])
    else $error("scl pin not open drain");

  a_serial_level_zero: assert property (mode_cfg[SERIAL_SEL_BIT] |=>
    level_seen[SDA_PIN] == 1'b0 && level_seen[SCL_PIN] == 1'b0)
    else $error("serial pin level not read as zero");

  a_serial_override: assert property (
    mode_cfg[SERIAL_SEL_BIT] ##1 mode_cfg[SERIAL_SEL_BIT] |->
    input_pulldown_resistor[SCL_PIN] == 1'b0 && pin_oe[SCL_PIN] == $past(scl_pull_low)
    && analog_sel[SCL_PIN] == 1'b0)
    else $error("scl pin not overridden by serial mode");

  a_cfg_read_back: assert property (s_mode_setup_read |=>
    pready && prdata[15:0] == $past(mode_cfg))
    else $error("mode register read back wrong");

  a_analog_high_z: assert property (!mode_cfg[DIGITAL_SEL_LSB+2] |=>
    analog_sel[2] && !pin_oe[2] && !input_pulldown_resistor[2])
    else $error("analog pin not high impedance");

  a_input_pulldown: assert property (
    mode_cfg[DIGITAL_SEL_LSB+3] && !mode_cfg[DIRECTION_LSB+3] |=>
    input_pulldown_resistor[3] && !pin_oe[3])
    else $error("gpio input without pull-down");

  a_output_drive: assert property (
    mode_cfg[DIGITAL_SEL_LSB+4] && mode_cfg[DIRECTION_LSB+4] |=>
    pin_oe[4] && input_buf_en[4] && !input_pulldown_resistor[4]
    && pin_out[4] == $past(drive_cfg[DRIVE_VALUE_LSB+4]))
    else $error("gpio output not driven");

  a_unmapped_error: assert property (psel && !penable && !addr_mode && !addr_drive |=>
    pready && pslverr ##1 !pslverr)
    else $error("unmapped access not refused");
endmodule // agpc_top
`default_nettype wire

// [sim/agpc_pad_model.sv]
`default_nettype none
// ==========================================================================
// board side of the six pads: bus pull-ups on pins 0/1, optional drivers
module agpc_pad_model
(
  // clock
  input wire logic clock,
  // pad controls from the block
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] input_pulldown_resistor,
  // external drivers commanded by the bench
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  // level at the pads
  output logic [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] wobble = 6'h15;
  // an undriven pad with no pull flips every cycle, so a missing pull-down shows
  always @(posedge clock)
    wobble <= ~wobble;
  always_comb
    for (int k = 0; k < 6; k++)
      if (pin_oe[k])
        pin_in[k] = pin_out[k];
      else if (ext_en[k])
        pin_in[k] = ext_val[k];
      else if (k < 2)
        pin_in[k] = 1'b1;
      else if (input_pulldown_resistor[k])
        pin_in[k] = 1'b0;
      else
        pin_in[k] = wobble[k];
endmodule // agpc_pad_model
`default_nettype wire

// [sim/aux_gpio_pin_config_bench.sv]
`default_nettype none
`define CHK(got, exp) \
  begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module aux_gpio_pin_config_bench import agpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, sda_level;
  logic sda_pull_low = 0, scl_pull_low = 0;
  logic [3:0] pstrb = 4'h3;
  logic [5:0] pin_in, pin_out, pin_oe, pull, buf_en, analog_sel;
  logic [5:0] ext_en = 0, ext_val = 0;
  int failures = 0, checks_done = 0, cycles = 0;
  always #4 clock = ~clock;
  agpc_top agpc_top_i (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sda_pull_low(sda_pull_low),
    .scl_pull_low(scl_pull_low), .sda_level(sda_level), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .input_pulldown_resistor(pull),
    .input_buf_en(buf_en), .analog_sel(analog_sel));
  agpc_pad_model agpc_pad_model_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .input_pulldown_resistor(pull), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // ==========================================================================
  // bus and closing
  task automatic wrap_up;
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung bus ends the run instead of stalling it
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    // wait for the answer however long it takes; only the run's timeout ends a hang
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    apb(0, MODE_CFG_ADDR, 0);
    `CHK(rd, 32'h00003f00)
    `CHK(pull, 6'h3f)
    `CHK(analog_sel, 6'h00)
    `CHK(pin_oe, 6'h00)
  endtask
  task automatic t_reserved;
    apb(1, MODE_CFG_ADDR, 16'hffff);
    apb(0, MODE_CFG_ADDR, 0);
    `CHK(rd, 32'h0000bf3f)
    // low lane only: the high byte must keep its stored value
    pstrb <= 4'h1;
    apb(1, MODE_CFG_ADDR, 16'h0000);
    pstrb <= 4'h3;
    apb(0, MODE_CFG_ADDR, 0);
    `CHK(rd, 32'h0000bf00)
  endtask
  task automatic t_output_analog;
    apb(1, MODE_CFG_ADDR, 16'h033f);
    apb(1, DRIVE_CFG_ADDR, 16'h0100);
    pause(3);
    `CHK(analog_sel, 6'h3c)
    `CHK(pin_oe, 6'h03)
    `CHK(pull, 6'h00)
    `CHK(pin_out[1:0], 2'b01)
    `CHK(buf_en[1:0], 2'b11)
    `CHK(buf_en[5:2], 4'h0)
    apb(0, DRIVE_CFG_ADDR, 0);
    `CHK(rd, 32'h00000101)
  endtask
  task automatic t_input;
    ext_en <= 6'h08;
    ext_val <= 6'h08;
    apb(1, MODE_CFG_ADDR, 16'h3f00);
    pause(3);
    `CHK(pull, 6'h3f)
    `CHK(pin_oe, 6'h00)
    apb(0, DRIVE_CFG_ADDR, 0);
    `CHK(rd, 32'h0000010b)
    ext_en <= 6'h00;
  endtask
  task automatic t_serial;
    apb(1, MODE_CFG_ADDR, 16'h8000);
    sda_pull_low <= 1'b1;
    pause(4);
    `CHK(pin_oe[1:0], 2'b01)
    `CHK(pin_out[1:0], 2'b00)
    `CHK(analog_sel[1:0], 2'b00)
    `CHK(pull[1:0], 2'b00)
    `CHK(sda_level, 1'b0)
    sda_pull_low <= 1'b0;
    scl_pull_low <= 1'b1;
    pause(4);
    `CHK(pin_oe[1:0], 2'b10)
    `CHK(sda_level, 1'b1)
    ext_en <= 6'h01;
    pause(3);
    `CHK(sda_level, 1'b0)
    ext_en <= 6'h00;
    apb(1, MODE_CFG_ADDR, 16'h8303);
    pause(3);
    `CHK(pin_oe[1:0], 2'b10)
    `CHK(pin_out[1:0], 2'b00)
    apb(0, MODE_CFG_ADDR, 0);
    `CHK(rd, 32'h00008303)
    apb(0, DRIVE_CFG_ADDR, 0);
    `CHK(rd, 32'h00000100)
    scl_pull_low <= 1'b0;
  endtask
  task automatic t_unmapped;
    apb(1, 12'h060, 16'h0000);
    `CHK(er, 1'b1)
    apb(0, 12'h060, 0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h00000000)
    apb(0, MODE_CFG_ADDR, 0);
    `CHK(rd, 32'h00008303)
  endtask
  initial
  begin
    pause(4);
    rstn <= 1'b1;
    t_reset();
    t_reserved();
    t_output_analog();
    t_input();
    t_serial();
    t_unmapped();
    wrap_up();
  end
endmodule // aux_gpio_pin_config_bench
`default_nettype wire
